// [common/gauge_ctrl_pkg.sv]
// Package for the gauge power, calibration and profile control block.
// Assumes measurement words arrive already scaled from the analog front end.
package gauge_ctrl_pkg;

  // Clock and timing
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint TEMP_HOLD_S   = 60;
  localparam longint TEMP_HOLD_CYC = TEMP_HOLD_S * CLK_HZ;
  localparam int     HOLD_W        = 34;

  // Calibration figures (mA, mV, 0.1 degC)
  localparam logic signed [15:0] CAL_MAX_MA   = 16'sh0064;
  localparam logic        [15:0] CAL_DV_MV    = 16'h0100;
  localparam logic        [15:0] CAL_DROP_MV  = 16'h0020;
  localparam logic signed [11:0] CAL_DT_DC    = 12'sh050;
  localparam logic signed [11:0] CAL_T_LO_DC  = 12'sh032;
  localparam logic signed [11:0] CAL_T_HI_DC  = 12'sh1C2;

  // Wake thresholds in microvolts
  localparam logic [15:0] TH_1P0_UV = 16'h03E8;
  localparam logic [15:0] TH_2P2_UV = 16'h0898;
  localparam logic [15:0] TH_4P6_UV = 16'h11F8;
  localparam logic [15:0] TH_9P8_UV = 16'h2648;

  // Extended command and status byte layout
  localparam logic [7:0] CMD_APP_STATUS = 8'h6A;
  localparam logic [7:0] APP_STATUS_RST = 8'h00;
  localparam int         ST_LAST_BIT    = 0;
  localparam int         ST_UNSUP_BIT   = 1;

  typedef struct packed {
    logic        [15:0] cell_mv;
    logic signed [15:0] avg_ma;
    logic signed [11:0] temp_dc;
    logic signed [15:0] sense_uv;
  } meas_t;

  typedef struct packed {
    logic [15:0] hib_current_ma;
    logic [15:0] hib_voltage_mv;
    logic [15:0] flash_min_mv;
    logic        sense_range_sel_hi;
    logic        sense_range_sel_lo;
    logic        wake_range_sel;
  } cfg_t;

  typedef enum logic [2:0] {
    PWR_INIT = 3'h1,
    PWR_RUN  = 3'h2,
    PWR_HIB  = 3'h4
  } pwr_state_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'h1,
    CAL_RUN  = 2'h2
  } cal_state_t;

endpackage

// [core/wake_comparator.sv]
// Wake comparator: threshold selection and crossing detection.
// Assumes the sense voltage is a signed microvolt sample each clock.
`timescale 1ns/1ps
module wake_comparator
  import gauge_ctrl_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_enable,
  input  wire logic               i_sense_range_sel_hi,
  input  wire logic               i_sense_range_sel_lo,
  input  wire logic               i_wake_range_sel,
  input  wire logic signed [15:0] i_sense_uv,
  output logic                    o_wake_irq,
  output logic             [15:0] o_thresh_uv
);

  logic [15:0] th_next;
  logic [15:0] mag;
  logic        hit;
  logic        hit_reg;

  // Threshold table, 00 disables
  always_comb begin
    unique case ({i_sense_range_sel_hi, i_sense_range_sel_lo})
      2'b01:   th_next = i_wake_range_sel ? TH_2P2_UV : TH_1P0_UV;
      2'b10:   th_next = i_wake_range_sel ? TH_4P6_UV : TH_2P2_UV;
      2'b11:   th_next = i_wake_range_sel ? TH_9P8_UV : TH_4P6_UV;
      default: th_next = 16'h0000;
    endcase
  end

  assign mag = i_sense_uv[15] ? 16'(-i_sense_uv) : 16'(i_sense_uv);
  // Either direction counts
  assign hit = i_enable && (th_next != 16'h0000) && (mag >= th_next);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hit_reg     <= 1'b0;
      o_wake_irq  <= 1'b0;
      o_thresh_uv <= 16'h0000;
    end else begin
      hit_reg     <= hit;
      o_wake_irq  <= hit && !hit_reg;
      o_thresh_uv <= th_next;
    end
  end

  a_wake_disabled: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_sense_range_sel_hi && !i_sense_range_sel_lo |=> !o_wake_irq)
    else $error("wake raised with comparator disabled");

endmodule

// [core/gauge_power_calibration_control.sv]
// Gauge power modes, reset handling, flash gate, calibration, profiles.
// Assumes an external serial engine decodes commands into the pulses here.
//
// Summary of operation
// - Requested hibernate waits for valid OCV and small average current.
// - Hibernate also entered on low cell voltage with valid OCV.
// - Hibernate lasts until an addressed transaction or power-on reset.
// - Traffic for other bus devices is ignored while hibernating.
// - Battery-good output held disabled around hibernate.
// - Software reset is classified and its per-type counter incremented.
// - Partial reset checks RAM checksum; mismatch forces full reinit.
// - Stored RAM checksum refreshed whenever RAM changes.
// - In sleep or hibernate, threshold crossing either way raises wake.
// - Range bits pick threshold; 00 disables the comparator.
// - Flash writes refused below the flash write minimum voltage.
// - Calibration starts on sleep entry only with temperature strictly between 5 and 45C.
// - Single calibration on low current with voltage or temperature drift.
// - During calibration current keeps the last measured rate.
// - Calibration aborts if voltage falls over 32 mV meanwhile.
// - Calibrated offset is subtracted from the corrected sense output; the wake comparator sees raw readings.
// - Status byte at 0x6a: bit1 unsupported, bit0 last profile.
// - Battery-good stays off until first OCV, then turns on.
// - First insertion copies the default profile into dynamic profiles.
// - Matching dynamic profile reused, else default over the oldest.
`timescale 1ns/1ps
module gauge_power_calibration_control
  import gauge_ctrl_pkg::*;
#(
  parameter logic [HOLD_W-1:0] P_TEMP_HOLD_CYC = HOLD_W'(TEMP_HOLD_CYC)
)(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire meas_t              i_meas,
  input  wire cfg_t               i_cfg,
  input  wire logic               i_hib_req_set,
  input  wire logic               i_i2c_addr_match,
  input  wire logic               i_i2c_other,
  input  wire logic               i_ocv_done,
  input  wire logic               i_sleep,
  input  wire logic               i_sw_reset,
  input  wire logic               i_reset_partial,
  input  wire logic               i_ram_alter,
  input  wire logic        [15:0] i_ram_sum,
  input  wire logic               i_flash_wr_req,
  input  wire logic               i_cal_done,
  input  wire logic signed [15:0] i_cal_offset_uv,
  input  wire logic               i_imp_match0,
  input  wire logic               i_imp_match1,
  input  wire logic               i_unsup_pack,
  input  wire logic               i_rd_strobe,
  input  wire logic        [7:0]  i_rd_cmd,
  output logic                    o_battery_good_out,
  output logic                    o_hibernating,
  output logic                    o_hib_req_bit,
  output logic                    o_init_restart,
  output logic             [7:0]  o_reset_cnt_partial,
  output logic             [7:0]  o_reset_cnt_full,
  output logic                    o_ram_reinit,
  output logic                    o_flash_wr_grant,
  output logic                    o_flash_wr_refused,
  output logic                    o_wake_irq,
  output logic             [15:0] o_wake_thresh_uv,
  output logic                    o_cal_start,
  output logic                    o_cal_abort,
  output logic                    o_cal_active,
  output logic signed      [15:0] o_held_ma,
  output logic signed      [15:0] o_corr_sense_uv,
  output logic                    o_copy_default,
  output logic             [1:0]  o_copy_dst,
  output logic             [7:0]  o_rd_data
);

  pwr_state_t              pwr_reg;
  pwr_state_t              pwr_next;
  cal_state_t              cal_reg;
  logic                    ocv_valid_reg;
  logic                    sleep_reg;
  logic             [15:0] ram_sum_reg;
  logic signed      [15:0] offset_reg;
  logic             [15:0] cal_mv_reg;
  logic signed      [11:0] cal_temp_reg;
  logic             [15:0] start_mv_reg;
  logic        [HOLD_W-1:0] hold_cnt_reg;
  logic             [1:0]  dyn_valid_reg;
  logic                    last_reg;
  logic                    unsup_reg;
  logic             [15:0] avg_mag;
  logic             [15:0] dv_mag;
  logic signed      [11:0] dt;
  logic                    hib_enter;
  logic                    wake;
  logic                    sleep_entry;
  logic                    temp_ok;
  logic                    drift_trig;
  logic                    cal_go;
  logic                    cal_drop;
  logic                    temp_drift;
  logic                    select_now;

  assign avg_mag = i_meas.avg_ma[15] ? 16'(-i_meas.avg_ma)
                                     : 16'(i_meas.avg_ma);
  assign dv_mag  = (i_meas.cell_mv >= cal_mv_reg)
                 ? 16'(i_meas.cell_mv - cal_mv_reg)
                 : 16'(cal_mv_reg - i_meas.cell_mv);
  assign dt      = 12'(i_meas.temp_dc - cal_temp_reg);

  // Hibernate entry, request driven or low voltage
  assign hib_enter = ocv_valid_reg &&
    ((o_hib_req_bit && (avg_mag < i_cfg.hib_current_ma))
     || (i_meas.cell_mv < i_cfg.hib_voltage_mv));
  // Only traffic addressed to the gauge wakes it
  assign wake       = (pwr_reg == PWR_HIB) && i_i2c_addr_match;
  assign select_now = (pwr_reg == PWR_INIT) && i_ocv_done;

  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_INIT: if (i_ocv_done) pwr_next = PWR_RUN;
      PWR_RUN:  if (hib_enter) pwr_next = PWR_HIB;
      PWR_HIB:  if (wake) pwr_next = PWR_INIT;
      default:  pwr_next = PWR_INIT;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_reg            <= PWR_INIT;
      ocv_valid_reg      <= 1'b0;
      o_battery_good_out <= 1'b0;
      o_init_restart     <= 1'b0;
    end else begin
      pwr_reg        <= pwr_next;
      o_init_restart <= wake;
      if (wake)
        ocv_valid_reg <= 1'b0;
      else if (select_now)
        ocv_valid_reg <= 1'b1;
      // Off in init and hibernate so no charging before an OCV
      o_battery_good_out <= (pwr_next == PWR_RUN);
    end
  end

  assign o_hibernating = (pwr_reg == PWR_HIB);

  // Hibernate request bit, set wins over clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      o_hib_req_bit <= 1'b0;
    else if (i_hib_req_set)
      o_hib_req_bit <= 1'b1;
    else if (wake)
      o_hib_req_bit <= 1'b0;
  end

  // Software reset classification and RAM checksum
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reset_cnt_partial <= 8'h00;
      o_reset_cnt_full    <= 8'h00;
      o_ram_reinit        <= 1'b0;
    end else begin
      o_ram_reinit <= i_sw_reset &&
        (!i_reset_partial || (i_ram_sum != ram_sum_reg));
      if (i_sw_reset && i_reset_partial)
        o_reset_cnt_partial <= o_reset_cnt_partial + 8'h01;
      if (i_sw_reset && !i_reset_partial)
        o_reset_cnt_full <= o_reset_cnt_full + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      ram_sum_reg <= 16'h0000;
    else if (i_ram_alter)
      ram_sum_reg <= i_ram_sum;
  end

  // Flash write voltage gate
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flash_wr_grant   <= 1'b0;
      o_flash_wr_refused <= 1'b0;
    end else begin
      o_flash_wr_grant   <= i_flash_wr_req &&
                            (i_meas.cell_mv >= i_cfg.flash_min_mv);
      o_flash_wr_refused <= i_flash_wr_req &&
                            (i_meas.cell_mv < i_cfg.flash_min_mv);
    end
  end

  wake_comparator u_wake (
    .i_ref_clk            (i_ref_clk),
    .i_rst                (i_rst),
    .i_enable             (i_sleep || o_hibernating),
    .i_sense_range_sel_hi (i_cfg.sense_range_sel_hi),
    .i_sense_range_sel_lo (i_cfg.sense_range_sel_lo),
    .i_wake_range_sel     (i_cfg.wake_range_sel),
    .i_sense_uv           (i_meas.sense_uv),
    .o_wake_irq           (o_wake_irq),
    .o_thresh_uv          (o_wake_thresh_uv)
  );

  // Calibration triggers
  assign sleep_entry = i_sleep && !sleep_reg;
  assign temp_ok     = (i_meas.temp_dc > CAL_T_LO_DC) &&
                       (i_meas.temp_dc < CAL_T_HI_DC);
  assign temp_drift  = (dt > CAL_DT_DC) || (dt < -CAL_DT_DC);
  assign drift_trig  = (i_meas.avg_ma <= CAL_MAX_MA) &&
                       ((dv_mag >= CAL_DV_MV) ||
                        (hold_cnt_reg >= P_TEMP_HOLD_CYC));
  assign cal_go      = (cal_reg == CAL_IDLE) &&
                       ((sleep_entry && temp_ok) || drift_trig);
  assign cal_drop    = (start_mv_reg > i_meas.cell_mv) &&
                       (16'(start_mv_reg - i_meas.cell_mv) > CAL_DROP_MV);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      hold_cnt_reg <= '0;
    else if (!temp_drift || cal_go)
      hold_cnt_reg <= '0;
    else if (hold_cnt_reg < P_TEMP_HOLD_CYC)
      hold_cnt_reg <= hold_cnt_reg + HOLD_W'(1);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_reg      <= CAL_IDLE;
      sleep_reg    <= 1'b0;
      start_mv_reg <= 16'h0000;
      cal_mv_reg   <= 16'h0000;
      cal_temp_reg <= 12'sh000;
      offset_reg   <= 16'sh0000;
      o_cal_start  <= 1'b0;
      o_cal_abort  <= 1'b0;
    end else begin
      sleep_reg   <= i_sleep;
      o_cal_start <= cal_go;
      o_cal_abort <= 1'b0;
      unique case (cal_reg)
        CAL_IDLE: if (cal_go) begin
          cal_reg      <= CAL_RUN;
          start_mv_reg <= i_meas.cell_mv;
        end
        CAL_RUN: if (cal_drop) begin
          cal_reg     <= CAL_IDLE;
          o_cal_abort <= 1'b1;
        end else if (i_cal_done) begin
          cal_reg      <= CAL_IDLE;
          offset_reg   <= i_cal_offset_uv;
          cal_mv_reg   <= i_meas.cell_mv;
          cal_temp_reg <= i_meas.temp_dc;
        end
        default: cal_reg <= CAL_IDLE;
      endcase
    end
  end

  assign o_cal_active = (cal_reg == CAL_RUN);

  // Current held at last rate, offset removed from sense data
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_held_ma       <= 16'sh0000;
      o_corr_sense_uv <= 16'sh0000;
    end else begin
      if (!o_cal_active)
        o_held_ma <= i_meas.avg_ma;
      o_corr_sense_uv <= 16'(i_meas.sense_uv - offset_reg);
    end
  end

  // Profile selection after the first OCV
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dyn_valid_reg  <= 2'b00;
      last_reg       <= 1'b0;
      unsup_reg      <= 1'b0;
      o_copy_default <= 1'b0;
      o_copy_dst     <= 2'b00;
    end else begin
      o_copy_default <= 1'b0;
      if (select_now) begin
        unsup_reg <= i_unsup_pack;
        if (dyn_valid_reg == 2'b00) begin
          dyn_valid_reg  <= 2'b11;
          last_reg       <= 1'b0;
          o_copy_default <= 1'b1;
          o_copy_dst     <= 2'b11;
        end else if (i_imp_match0 && dyn_valid_reg[0]) begin
          last_reg <= 1'b0;
        end else if (i_imp_match1 && dyn_valid_reg[1]) begin
          last_reg <= 1'b1;
        end else begin
          last_reg       <= !last_reg;
          o_copy_default <= 1'b1;
          o_copy_dst     <= last_reg ? 2'b01 : 2'b10;
          dyn_valid_reg  <= 2'b11;
        end
      end
    end
  end

  // Extended command read port
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      o_rd_data <= APP_STATUS_RST;
    else if (i_rd_strobe) begin
      o_rd_data <= 8'h00;
      if (i_rd_cmd == CMD_APP_STATUS) begin
        o_rd_data[ST_UNSUP_BIT] <= unsup_reg;
        o_rd_data[ST_LAST_BIT]  <= last_reg;
      end
    end
  end

  a_hib_entry_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pwr_reg == PWR_RUN && $past(pwr_reg) == PWR_RUN && pwr_next == PWR_HIB
    |-> ocv_valid_reg)
    else $error("hibernate entered without valid OCV");
  a_hib_stays: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pwr_reg == PWR_HIB && !i_i2c_addr_match |=> pwr_reg == PWR_HIB)
    else $error("hibernate left without addressed access");
  a_other_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pwr_reg == PWR_HIB && i_i2c_other && !i_i2c_addr_match
    |=> !o_init_restart)
    else $error("woke on foreign traffic");
  a_batgd_off_hib: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    pwr_reg == PWR_HIB |=> !o_battery_good_out [*2])
    else $error("battery good active around hibernate");
  a_req_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wake && !i_hib_req_set |=> !o_hib_req_bit && o_init_restart)
    else $error("request bit kept after wake");
  a_flash_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_flash_wr_req && i_meas.cell_mv < i_cfg.flash_min_mv
    |=> o_flash_wr_refused && !o_flash_wr_grant)
    else $error("flash write granted at low voltage");
  a_cal_abort: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cal_active && cal_drop |=> o_cal_abort && !o_cal_active)
    else $error("calibration not aborted on voltage drop");
  a_offset_sub: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ##1 o_corr_sense_uv == 16'($past(i_meas.sense_uv) - $past(offset_reg)))
    else $error("offset not subtracted");
  a_status_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rd_strobe && i_rd_cmd == CMD_APP_STATUS
    |=> o_rd_data == {6'h00, $past(unsup_reg), $past(last_reg)})
    else $error("status byte wrong");

endmodule

// [verif/gauge_host_model.sv]
// Host controller model: drives the decoded serial-engine strobes.
// Assumes calls come from one process; strobes change at falling edges.
`timescale 1ns/1ps
module gauge_host_model (
  input  wire logic       i_ref_clk,
  output logic            o_hib_req_set,
  output logic            o_i2c_addr_match,
  output logic            o_i2c_other,
  output logic            o_rd_strobe,
  output logic      [7:0] o_rd_cmd
);
  initial begin
    {o_hib_req_set, o_i2c_addr_match, o_i2c_other, o_rd_strobe} = 4'h0;
    o_rd_cmd = 8'h00;
  end

  // Kind 0 hibernate request, 1 addressed, 2 other device, 3 read
  task automatic send(input int kind, input logic [7:0] cmd);
    @(negedge i_ref_clk);
    o_hib_req_set    = (kind == 0);
    o_i2c_addr_match = (kind == 1);
    o_i2c_other      = (kind == 2);
    o_rd_strobe      = (kind == 3);
    o_rd_cmd         = cmd;
    @(negedge i_ref_clk);
    {o_hib_req_set, o_i2c_addr_match, o_i2c_other, o_rd_strobe} = 4'h0;
    o_rd_cmd = ~cmd;
  endtask
endmodule

// [verif/gauge_power_calibration_control_tb.sv]
// Self-checking bench for the power, calibration and profile block.
// Assumes the host model drives the serial-engine strobes.
`timescale 1ns/1ps
module gauge_power_calibration_control_tb
  import gauge_ctrl_pkg::*;
;
  logic               i_ref_clk;
  logic               i_rst;
  logic               ocv, sleep, swr, part, alter, fwr, cdone, m0, m1;
  logic               unsup, hreq, amatch, other, rstb, last, dyn, ecp;
  logic        [15:0] rsum, sum_ref, thr;
  logic signed [15:0] coff, held, corr;
  meas_t              meas;
  cfg_t               cfg;
  logic        [7:0]  rcmd, rd, cnt_p, cnt_f;
  logic               batgd, hib, hbit, restart, reinit, grant, refused;
  logic               irq, cstart, cabort, cact, copy;
  logic        [1:0]  dst, dst_seen, edst;
  logic        [15:0] thr_tab [8] = '{16'h0000, 16'h0000, TH_1P0_UV,
    TH_2P2_UV, TH_2P2_UV, TH_4P6_UV, TH_4P6_UV, TH_9P8_UV};
  int                 error_cnt, n_tests, cycles, i, k, cnt_pe, cnt_fe;
  int                 n_st, n_ab, n_irq, n_rs, n_cp;

  gauge_power_calibration_control #(.P_TEMP_HOLD_CYC(HOLD_W'(20))) DUT (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_meas(meas), .i_cfg(cfg),
    .i_hib_req_set(hreq), .i_i2c_addr_match(amatch), .i_i2c_other(other),
    .i_ocv_done(ocv), .i_sleep(sleep), .i_sw_reset(swr),
    .i_reset_partial(part), .i_ram_alter(alter), .i_ram_sum(rsum),
    .i_flash_wr_req(fwr), .i_cal_done(cdone), .i_cal_offset_uv(coff),
    .i_imp_match0(m0), .i_imp_match1(m1), .i_unsup_pack(unsup),
    .i_rd_strobe(rstb), .i_rd_cmd(rcmd), .o_battery_good_out(batgd),
    .o_hibernating(hib), .o_hib_req_bit(hbit), .o_init_restart(restart),
    .o_reset_cnt_partial(cnt_p), .o_reset_cnt_full(cnt_f),
    .o_ram_reinit(reinit), .o_flash_wr_grant(grant),
    .o_flash_wr_refused(refused), .o_wake_irq(irq), .o_wake_thresh_uv(thr),
    .o_cal_start(cstart), .o_cal_abort(cabort), .o_cal_active(cact),
    .o_held_ma(held), .o_corr_sense_uv(corr), .o_copy_default(copy),
    .o_copy_dst(dst), .o_rd_data(rd)
  );

  gauge_host_model host (
    .i_ref_clk(i_ref_clk), .o_hib_req_set(hreq), .o_i2c_addr_match(amatch),
    .o_i2c_other(other), .o_rd_strobe(rstb), .o_rd_cmd(rcmd)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // Pulse counters and cycle ceiling
  always @(posedge i_ref_clk) begin
    n_st += (cstart === 1'b1);
    n_ab += (cabort === 1'b1);
    n_irq += (irq === 1'b1);
    n_rs += (restart === 1'b1);
    n_cp += (copy === 1'b1);
    if (copy === 1'b1) dst_seen = dst;
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    i_rst = 1'b1;
    {ocv, sleep, swr, part, alter, fwr, cdone, m0, m1, unsup} = '0;
    {rsum, sum_ref, coff, last, dyn} = '0;
    meas = '0;
    meas.cell_mv = 16'h0E10;
    meas.avg_ma = 16'sh01F4;
    cfg = '0;
    cfg.hib_current_ma = 16'h0064;
    cfg.flash_min_mv = 16'h0C80;
    void'($urandom(32'hBC511C2B));
    cyc(3);
    i_rst = 1'b0;
    host.send(3, CMD_APP_STATUS);
    chk("status_reset", rd, APP_STATUS_RST);
    for (i = 0; i < 12; i++) begin
      k = (i < 3) ? i : $urandom_range(800) - 384;
      meas.cell_mv = 16'h0C7F + 16'(k);
      pulse(fwr);
      chk("flash_gate", {grant, refused}, {k >= 1, k < 1});
    end
    meas.cell_mv = 16'h0E10;
    for (i = 0; i < 24; i++) begin
      if ($urandom_range(1)) begin
        rsum = 16'($urandom);
        pulse(alter);
        sum_ref = rsum;
      end
      part = $urandom_range(1);
      rsum = $urandom_range(1) ? sum_ref : 16'($urandom);
      pulse(swr);
      cnt_pe += part;
      cnt_fe += !part;
      chk("ram_reinit", reinit, !part || rsum != sum_ref);
      chk("reset_counts", {cnt_p, cnt_f}, {8'(cnt_pe), 8'(cnt_fe)});
    end
    sleep = 1'b1;
    for (i = 0; i < 8; i++) begin
      meas.sense_uv = 16'sh0000;
      {cfg.sense_range_sel_hi, cfg.sense_range_sel_lo, cfg.wake_range_sel}
        = i[2:0];
      cyc(3);
      k = n_irq;
      meas.sense_uv = thr_tab[i] - 16'h0001;
      cyc(3);
      meas.sense_uv = (i < 2) ? 16'sh7FFF : i[0] ? -thr_tab[i] : thr_tab[i];
      cyc(3);
      if (i > 1) chk("wake_threshold", thr, thr_tab[i]);
      chk("wake_irq", n_irq - k, i > 1);
    end
    meas.sense_uv = 16'sh0000;
    sleep = 1'b0;
    cyc(3);
    k = n_irq;
    meas.sense_uv = thr_tab[7];
    cyc(3);
    chk("wake_awake", n_irq - k, 0);
    meas.temp_dc = CAL_T_HI_DC;
    k = n_st;
    sleep = 1'b1;
    cyc(4);
    chk("cal_start_hot", n_st - k, 0);
    sleep = 1'b0;
    meas.temp_dc = CAL_T_HI_DC - 12'sh001;
    cyc(1);
    sleep = 1'b1;
    cyc(3);
    chk("cal_start", n_st - k, 1);
    chk("cal_active", cact, 1);
    meas.avg_ma = 16'sh02BC;
    meas.cell_mv = 16'h0E10 - CAL_DROP_MV;
    k = n_ab;
    cyc(3);
    chk("held_current", held, 16'h01F4);
    chk("cal_abort_edge", n_ab - k, 0);
    meas.cell_mv = meas.cell_mv - 16'h0001;
    cyc(3);
    chk("cal_abort", n_ab - k, 1);
    chk("cal_aborted", cact, 0);
    meas.cell_mv = 16'h0E10;
    sleep = 1'b0;
    cyc(1);
    sleep = 1'b1;
    cyc(3);
    coff = 16'($urandom_range(4000)) - 16'sh07D0;
    pulse(cdone);
    chk("cal_done", cact, 0);
    meas.sense_uv = 16'($urandom_range(8000)) - 16'sh0FA0;
    cyc(2);
    chk("corrected_sense", corr, 16'(meas.sense_uv - coff));
    meas.avg_ma = CAL_MAX_MA;
    meas.cell_mv = 16'h0E10 + CAL_DV_MV - 16'h0001;
    k = n_st;
    cyc(4);
    chk("cal_dv_edge", n_st - k, 0);
    meas.cell_mv = 16'h0E10 + CAL_DV_MV;
    cyc(3);
    chk("cal_dv", n_st - k, 1);
    pulse(cdone);
    meas.temp_dc = CAL_T_HI_DC - 12'sh002 - CAL_DT_DC;
    k = n_st;
    cyc(15);
    chk("cal_dt_early", n_st - k, 0);
    cyc(12);
    chk("cal_dt", n_st - k, 1);
    pulse(cdone);
    sleep = 1'b0;
    for (k = 0; k < 4; k++) begin
      {m1, m0} = 2'(k == 1 ? 2 : k == 3 ? 1 : 0);
      unsup = k[0];
      i = n_cp;
      chk("battery_good_init", batgd, 0);
      pulse(ocv);
      cyc(2);
      ecp = !dyn || !(m0 || m1);
      edst = !dyn ? 2'h3 : (last ? 2'h1 : 2'h2);
      last = !dyn ? 1'b0 : m0 ? 1'b0 : m1 ? 1'b1 : !last;
      dyn = 1'b1;
      chk("copy_default", n_cp - i, ecp);
      if (ecp) chk("copy_target", dst_seen, edst);
      chk("battery_good", batgd, 1);
      host.send(3, CMD_APP_STATUS);
      chk("status", rd, {6'h00, unsup, last});
      host.send(3, 8'h6B);
      chk("status_other", rd, 8'h00);
      meas.avg_ma = k[1] ? -16'sh01F4 : 16'sh01F4;
      if (!k[0]) begin
        host.send(0, 8'h00);
        cyc(3);
        chk("hib_wait", {hbit, hib}, 2'h2);
        cfg.hib_current_ma = 16'h03E8;
      end else cfg.hib_voltage_mv = meas.cell_mv + 16'h0001;
      cyc(3);
      chk("hibernate", {hib, batgd}, 2'h2);
      cfg.hib_current_ma = 16'h0064;
      cfg.hib_voltage_mv = 16'h0000;
      host.send(2, 8'h00);
      cyc(2);
      chk("hib_other", hib, 1);
      i = n_rs;
      host.send(1, 8'h00);
      cyc(2);
      chk("wake", {hib, hbit, batgd}, 3'h0);
      chk("restart", n_rs - i, 1);
    end
    conclude();
  end
endmodule
